/* File: rtl/csr_charger_status.sv */
// Charger status register bank with charge phase event flag
`timescale 1ns/1ps
module csr_charger_status
(
  input  wire logic                    REF_CLK,
  input  wire logic                    SRST,
  input  wire logic                    CLK_EN,
  input  wire csr_pkg::csr_status_in_t STATUS_IN,
  input  wire logic                    WEAK_SOURCE_STROBE,
  input  wire logic                    WEAK_SOURCE_SEEN,
  input  wire logic                    RD_EN,
  input  wire logic                    WR_EN,
  input  wire logic [7:0]              ADDR,
  input  wire logic                    EVENT_SERVICE,
  output logic [7:0]                   RD_DATA,
  output logic                         RD_VALID,
  output logic                         CHARGE_PHASE_EVENT
);

  // ----------------------------------------------------------------
  // Status assembly
  // ----------------------------------------------------------------
  logic [2:0] weak_count;
  logic [2:0] next_weak_count;
  logic [2:0] phase_prev;
  logic [2:0] next_phase_prev;
  logic [2:0] charge_phase;
  logic [2:0] source_code;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] thermistor_status;
  logic [7:0] fault_status;
  logic [7:0] next_rd_data;
  logic       next_rd_valid;
  logic       next_event;

  always_comb
  begin
    if (STATUS_IN.battery_below_short)
      charge_phase = csr_pkg::CSR_PH_TRICKLE;
    else if (STATUS_IN.battery_in_low_window)
      charge_phase = csr_pkg::CSR_PH_PRE;
    else
      charge_phase = STATUS_IN.core_charge_phase;
    if (weak_count == csr_pkg::CSR_WEAK_LIMIT)
      source_code = csr_pkg::CSR_SRC_WEAK;
    else
      source_code = STATUS_IN.input_source_type;
    status_one = csr_pkg::CSR_READ_RESET;
    status_one[csr_pkg::CSR_S1_IREG_BIT] = STATUS_IN.input_current_reg_active;
    status_one[csr_pkg::CSR_S1_VREG_BIT] = STATUS_IN.input_voltage_reg_active;
    status_one[csr_pkg::CSR_S1_TREG_BIT] = STATUS_IN.die_thermal_reg_active;
    status_one[csr_pkg::CSR_S1_WDOG_BIT] = STATUS_IN.watchdog_expired;
    status_one[2:0] = charge_phase;
    status_two = csr_pkg::CSR_READ_RESET;
    status_two[csr_pkg::CSR_S2_PGOOD_BIT] = STATUS_IN.input_power_good;
    status_two[csr_pkg::CSR_S2_SRC_LSB +: 3] = source_code;
    status_two[csr_pkg::CSR_S2_ICO_LSB +: 2] = STATUS_IN.current_optimizer_state;
    thermistor_status = csr_pkg::CSR_READ_RESET;
    thermistor_status[2:0] = STATUS_IN.battery_temp_zone;
    fault_status = csr_pkg::CSR_READ_RESET;
    fault_status[csr_pkg::CSR_F_OVP_BIT] = STATUS_IN.input_overvoltage_active;
    fault_status[csr_pkg::CSR_F_TSHUT_BIT] = STATUS_IN.thermal_shutdown_active;
    fault_status[csr_pkg::CSR_F_TIMER_BIT] = STATUS_IN.safety_timer_expired;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_weak_count = weak_count;
    if (WEAK_SOURCE_STROBE)
    begin
      if (!WEAK_SOURCE_SEEN)
        next_weak_count = csr_pkg::CSR_WEAK_RESET;
      else if (weak_count != csr_pkg::CSR_WEAK_LIMIT)
        next_weak_count = weak_count + 3'h1;
    end
    // No input power with no weak source seen clears the history so a new source starts fresh
    if (!STATUS_IN.input_power_good && !WEAK_SOURCE_SEEN)
      next_weak_count = csr_pkg::CSR_WEAK_RESET;
    next_phase_prev = charge_phase;
    // sticky phase event, set wins over service
    next_event = CHARGE_PHASE_EVENT;
    if (EVENT_SERVICE)
      next_event = 1'b0;
    if (charge_phase != phase_prev)
      next_event = 1'b1;
    next_rd_valid = RD_EN && !WR_EN;
    next_rd_data = csr_pkg::CSR_READ_RESET;
    if (RD_EN && !WR_EN)
    begin
      unique case (ADDR)
        csr_pkg::CSR_ADDR_STATUS_ONE: next_rd_data = status_one;
        csr_pkg::CSR_ADDR_STATUS_TWO: next_rd_data = status_two;
        csr_pkg::CSR_ADDR_THERMISTOR: next_rd_data = thermistor_status;
        csr_pkg::CSR_ADDR_FAULT:      next_rd_data = fault_status;
        // Unmapped addresses read zero rather than stale data
        default:                      next_rd_data = csr_pkg::CSR_READ_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      weak_count         <= csr_pkg::CSR_WEAK_RESET;
      phase_prev         <= csr_pkg::CSR_PH_IDLE;
      CHARGE_PHASE_EVENT <= 1'b0;
      RD_DATA            <= csr_pkg::CSR_READ_RESET;
      RD_VALID           <= 1'b0;
    end
    else if (CLK_EN)
    begin
      weak_count         <= next_weak_count;
      phase_prev         <= next_phase_prev;
      CHARGE_PHASE_EVENT <= next_event;
      RD_DATA            <= next_rd_data;
      RD_VALID           <= next_rd_valid;
    end
  end

endmodule : csr_charger_status

/* File: rtl/csr_pkg.sv */
// Constants, types and field layout for the charger status register bank
package csr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_ADDR_STATUS_ONE  = 8'h0b;
  localparam logic [7:0] CSR_ADDR_STATUS_TWO  = 8'h0c;
  localparam logic [7:0] CSR_ADDR_THERMISTOR  = 8'h0d;
  localparam logic [7:0] CSR_ADDR_FAULT       = 8'h0e;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CSR_S1_IREG_BIT     = 6;
  localparam int CSR_S1_VREG_BIT     = 5;
  localparam int CSR_S1_TREG_BIT     = 4;
  localparam int CSR_S1_WDOG_BIT     = 3;
  localparam int CSR_S2_PGOOD_BIT    = 7;
  localparam int CSR_S2_SRC_LSB      = 4;
  localparam int CSR_S2_ICO_LSB      = 1;
  localparam int CSR_F_OVP_BIT       = 7;
  localparam int CSR_F_TSHUT_BIT     = 6;
  localparam int CSR_F_TIMER_BIT     = 4;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_READ_RESET    = 8'h00;
  localparam logic [2:0] CSR_WEAK_LIMIT    = 3'h7;
  localparam logic [2:0] CSR_WEAK_RESET    = 3'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSR_PH_IDLE    = 3'b000,
    CSR_PH_TRICKLE = 3'b001,
    CSR_PH_PRE     = 3'b010,
    CSR_PH_CC      = 3'b011,
    CSR_PH_CV      = 3'b100,
    CSR_PH_TOPOFF  = 3'b101,
    CSR_PH_DONE    = 3'b110
  } csr_phase_t;

  typedef enum logic [2:0] {
    CSR_SRC_NONE    = 3'b000,
    CSR_SRC_SDP     = 3'b001,
    CSR_SRC_CDP     = 3'b010,
    CSR_SRC_DCP     = 3'b011,
    CSR_SRC_WEAK    = 3'b100,
    CSR_SRC_UNKNOWN = 3'b101,
    CSR_SRC_NONSTD  = 3'b110
  } csr_source_t;

  // Live conditions from the charger core, same clock domain
  typedef struct packed {
    logic       input_current_reg_active;
    logic       input_voltage_reg_active;
    logic       die_thermal_reg_active;
    logic       watchdog_expired;
    logic       input_power_good;
    logic [2:0] input_source_type;
    logic [1:0] current_optimizer_state;
    logic [2:0] battery_temp_zone;
    logic       input_overvoltage_active;
    logic       thermal_shutdown_active;
    logic       safety_timer_expired;
    logic       battery_below_short;
    logic       battery_in_low_window;
    logic [2:0] core_charge_phase;
  } csr_status_in_t;

endpackage : csr_pkg

/* File: verification/csr_charger_status_asserts.sv */
// Property checker for the charger status register bank
`timescale 1ns/1ps
module csr_charger_status_asserts
(
  input wire logic                    REF_CLK,
  input wire logic                    SRST,
  input wire logic                    CLK_EN,
  input wire csr_pkg::csr_status_in_t STATUS_IN,
  input wire logic                    RD_EN,
  input wire logic                    WR_EN,
  input wire logic [7:0]              ADDR,
  input wire logic                    EVENT_SERVICE,
  input wire logic [7:0]              RD_DATA,
  input wire logic                    RD_VALID,
  input wire logic                    CHARGE_PHASE_EVENT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  csr_pkg::csr_status_in_t q;
  wire logic               rd = CLK_EN && RD_EN && !WR_EN;
  // Inputs as seen at the taking edge
  always_ff @(posedge REF_CLK) q <= STATUS_IN;
  chk_read_answer: assert property (rd |=> RD_VALID)
    else $error("read not answered");
  chk_no_spurious: assert property (CLK_EN && !rd |=> !RD_VALID)
    else $error("answer without read");
  chk_s1_flags: assert property (rd && ADDR == 8'h0b |=> RD_DATA[7:3] == {1'b0,
    q.input_current_reg_active, q.input_voltage_reg_active, q.die_thermal_reg_active,
    q.watchdog_expired}) else $error("status one flags wrong");
  chk_phase_code: assert property (rd && ADDR == 8'h0b && !STATUS_IN.battery_below_short
    && !STATUS_IN.battery_in_low_window |=> RD_DATA[2:0] == q.core_charge_phase)
    else $error("phase code wrong");
  chk_trickle_wins: assert property (rd && ADDR == 8'h0b && STATUS_IN.battery_below_short
    |=> RD_DATA[2:0] == 3'h1) else $error("trickle not reported");
  chk_pre_window: assert property (rd && ADDR == 8'h0b && !STATUS_IN.battery_below_short
    && STATUS_IN.battery_in_low_window |=> RD_DATA[2:0] == 3'h2)
    else $error("pre-charge not reported");
  chk_s2_fields: assert property (rd && ADDR == 8'h0c |=> RD_DATA[3] == 1'b0
    && RD_DATA[0] == 1'b0 && RD_DATA[2:1] == q.current_optimizer_state)
    else $error("status two fields wrong");
  chk_temp_zone: assert property (rd && ADDR == 8'h0d |=> RD_DATA == {5'h0,
    q.battery_temp_zone}) else $error("temperature zone wrong");
  chk_fault_bits: assert property (rd && ADDR == 8'h0e |=> RD_DATA == {
    q.input_overvoltage_active, q.thermal_shutdown_active, 1'b0, q.safety_timer_expired,
    4'h0}) else $error("fault byte wrong");
  chk_event_sticky: assert property (CHARGE_PHASE_EVENT && CLK_EN && !EVENT_SERVICE
    |=> CHARGE_PHASE_EVENT) else $error("event dropped unserviced");
endmodule : csr_charger_status_asserts
bind csr_charger_status csr_charger_status_asserts i_chk (.REF_CLK(REF_CLK), .SRST(SRST),
  .CLK_EN(CLK_EN), .STATUS_IN(STATUS_IN), .RD_EN(RD_EN), .WR_EN(WR_EN), .ADDR(ADDR),
  .EVENT_SERVICE(EVENT_SERVICE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .CHARGE_PHASE_EVENT(CHARGE_PHASE_EVENT));

/* File: verification/csr_host.sv */
// Host model issuing register reads and writes
`timescale 1ns/1ps
module csr_host
(
  input  wire logic       clk,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output logic            rd_en = 1'b0,
  output logic            wr_en = 1'b0,
  output logic [7:0]      addr = 8'h00
);
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    for (int n = 0; n < 4; n++)
    begin
      @(negedge clk);
      if (rd_valid === 1'b1)
      begin
        d = rd_data;
        ok = 1'b1;
        break;
      end
    end
    rd_en = 1'b0;
    // Inverted so a stale address never looks like a live request
    addr = ~a;
  endtask : read
  task automatic write(input logic [7:0] a);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    @(negedge clk);
    wr_en = 1'b0;
    addr = ~a;
  endtask : write
endmodule : csr_host

/* File: verification/csr_charger_status_tb_top.sv */
// Testbench for the charger status register bank
`timescale 1ns/1ps
module csr_charger_status_tb_top;
  logic                    clk = 0, srst = 1, strobe = 0, seen = 0, svc = 0, en = 1;
  csr_pkg::csr_status_in_t st = '0;
  logic                    rd_en, wr_en, rd_valid, ev;
  logic [7:0]              addr, rd_data, d;
  int                      err_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  csr_charger_status i_csr_charger_status (.REF_CLK(clk), .SRST(srst), .CLK_EN(en),
    .STATUS_IN(st), .WEAK_SOURCE_STROBE(strobe), .WEAK_SOURCE_SEEN(seen), .RD_EN(rd_en),
    .WR_EN(wr_en), .ADDR(addr), .EVENT_SERVICE(svc), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .CHARGE_PHASE_EVENT(ev));
  csr_host i_csr_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .rd_en(rd_en),
    .wr_en(wr_en), .addr(addr));
  task automatic finish_test;
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic ok;
    i_csr_host.read(a, d, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch read answer %h expected 1 seen %b", a, ok);
      finish_test();
    end
    else
      chk($sformatf("reg %h", a), exp, d);
  endtask : rd
  task automatic pulse(input int n, input logic s);
    repeat (n)
    begin
      @(negedge clk);
      strobe = 1'b1;
      seen = s;
      @(negedge clk);
      strobe = 1'b0;
    end
  endtask : pulse
  initial
  begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      automatic logic [2:0] x = 3'(i + 3);
      @(negedge clk);
      st = {4'(i + 9), i[0], 3'(i), 2'(i % 3), 3'(i), x, 2'b00, 3'(i)};
      rd(8'h0b, {1'b0, 4'(i + 9), 3'(i)});
      rd(8'h0c, {i[0], 3'(i), 1'b0, 2'(i % 3), 1'b0});
      rd(8'h0d, {5'h0, 3'(i)});
      rd(8'h0e, {x[2], x[1], 1'b0, x[0], 4'h0});
    end
    rd(8'h0a, 8'h00);
    i_csr_host.write(8'h0b);
    rd(8'h0b, 8'h7e);
    st.battery_below_short = 1'b1;
    rd(8'h0b, 8'h79);
    st.battery_below_short = 1'b0;
    st.battery_in_low_window = 1'b1;
    rd(8'h0b, 8'h7a);
    st.battery_in_low_window = 1'b0;
    st.input_power_good = 1'b1;
    pulse(6, 1'b1);
    rd(8'h0c, 8'he0);
    pulse(1, 1'b1);
    rd(8'h0c, 8'hc0);
    pulse(1, 1'b0);
    rd(8'h0c, 8'he0);
    chk("event set", 8'h01, {7'h0, ev});
    @(negedge clk);
    svc = 1'b1;
    @(negedge clk);
    svc = 1'b0;
    chk("event cleared", 8'h00, {7'h0, ev});
    st.core_charge_phase = 3'h3;
    repeat (3) @(negedge clk);
    chk("event on change", 8'h01, {7'h0, ev});
    // Service while the enable is low must be ignored
    en = 1'b0;
    svc = 1'b1;
    @(negedge clk);
    svc = 1'b0;
    en = 1'b1;
    chk("event frozen", 8'h01, {7'h0, ev});
    finish_test();
  end
endmodule : csr_charger_status_tb_top
